// >>> rap_port.sv
// Random access port of the shared buffer memory, with its command registers.
`timescale 1ns/1ps
module rap_port
   import rap_pkg::*;
#(
   parameter int ADDR_BITS = rap_pkg::ADDR_W,
   parameter int DATA_BITS = rap_pkg::DATA_W
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_BITS-1:0] word_address,
   input wire logic port_select_n,
   input wire logic reg_select_n,
   input wire logic read_write_n,
   input wire logic output_enable_n,
   input wire logic lower_byte_enable_n,
   input wire logic upper_byte_enable_n,
   input wire logic [DATA_BITS-1:0] random_data_bus_in,
   output logic [DATA_BITS-1:0] random_data_bus_out,
   output logic [DATA_BITS-1:0] random_data_bus_oe,
   output logic port_power_down,
   input wire logic seq_write_en,
   input wire logic [ADDR_BITS-1:0] seq_write_addr,
   input wire logic [DATA_BITS-1:0] seq_write_data,
   input wire logic [ADDR_BITS-1:0] seq_read_addr,
   output logic [DATA_BITS-1:0] seq_read_data,
   input wire logic seq_end_hit_first,
   input wire logic seq_end_hit_second,
   output logic [ADDR_BITS-1:0] start_addr_first,
   output logic [ADDR_BITS-1:0] end_addr_first,
   output logic [ADDR_BITS-1:0] start_addr_second,
   output logic [ADDR_BITS-1:0] end_addr_second,
   output logic [rap_pkg::REG_W-1:0] control_word,
   output logic buffer_end_flag_first,
   output logic buffer_end_flag_second
);
   import rap_pkg::*;

   localparam int WORDS = 1 << ADDR_BITS;
   localparam int HALF = DATA_BITS / 2;
   localparam int PIN_W = ADDR_BITS + DATA_BITS + 6;

   if (DATA_BITS != DATA_W || ADDR_BITS < SEL_W || ADDR_BITS > 16)
   begin : g_check
      $error("rap_port: data width must be 16 and address width 3 to 16");
   end

   // Every host pin is asynchronous, so the whole group passes two flip-flops.
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] sync0_reg;
   logic [PIN_W-1:0] sync1_reg;
   logic [ADDR_BITS-1:0] a_s;
   logic [DATA_BITS-1:0] din_s;
   logic ce_s;
   logic cmd_s;
   logic rw_s;
   logic oe_s;
   logic low_lane_s;
   logic high_lane_s;

   assign pin_raw = {word_address, random_data_bus_in, port_select_n, reg_select_n,
                     read_write_n, output_enable_n, lower_byte_enable_n, upper_byte_enable_n};

   always_ff @(posedge clock)
   begin
      sync0_reg <= pin_raw;
      sync1_reg <= sync0_reg;
   end

   assign {a_s, din_s, ce_s, cmd_s, rw_s, oe_s, low_lane_s, high_lane_s} = sync1_reg;

   logic [DATA_BITS-1:0] mem [WORDS];
   rap_mode_t mode_reg;
   rap_mode_t mode_next;
   logic [SEL_W-1:0] sel;
   logic cmd_write;
   logic ctrl_write;
   logic drive;
   logic [DATA_BITS-1:0] reg_read;
   logic [REG_W-1:0] flag_word;

   assign sel = a_s[SEL_W-1:0];

   // A host that lowers both selects gets neither target, so no access is half made.
   always_comb
   begin
      if (!ce_s && cmd_s)
         mode_next = MODE_ARRAY;
      else if (ce_s && !cmd_s)
         mode_next = MODE_CMD;
      else
         mode_next = MODE_IDLE;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         mode_reg <= MODE_IDLE;
      else
         mode_reg <= mode_next;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         port_power_down <= 1'b1;
      else
      begin
         case (mode_reg)
            MODE_IDLE: port_power_down <= (mode_next == MODE_IDLE);
            MODE_ARRAY: port_power_down <= (mode_next == MODE_IDLE);
            MODE_CMD: port_power_down <= (mode_next == MODE_IDLE);
            default: port_power_down <= 1'b1;
         endcase
      end
   end

   // A held write strobe rewrites the same word each cycle, which is harmless.
   // The sequential side is written last, so it wins a same-cycle conflict.
   always_ff @(posedge clock)
   begin
      if (mode_next == MODE_ARRAY && !rw_s)
      begin
         if (!low_lane_s)
            mem[a_s][HALF-1:0] <= din_s[HALF-1:0];
         if (!high_lane_s)
            mem[a_s][DATA_BITS-1:HALF] <= din_s[DATA_BITS-1:HALF];
      end
      if (seq_write_en)
         mem[seq_write_addr] <= seq_write_data;
   end

   always_ff @(posedge clock)
   begin
      seq_read_data <= mem[seq_read_addr];
   end

   assign cmd_write = (mode_next == MODE_CMD) && !rw_s;
   assign ctrl_write = cmd_write && (sel == REG_CONTROL);

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         start_addr_first <= START_RESET;
         end_addr_first <= END_RESET;
         start_addr_second <= START_RESET;
         end_addr_second <= END_RESET;
         control_word <= CTRL_RESET;
      end
      else if (cmd_write)
      begin
         if (sel == REG_START_FIRST)
            start_addr_first <= din_s[ADDR_BITS-1:0];
         else if (sel == REG_END_FIRST)
            end_addr_first <= din_s[ADDR_BITS-1:0];
         else if (sel == REG_START_SECOND)
            start_addr_second <= din_s[ADDR_BITS-1:0];
         else if (sel == REG_END_SECOND)
            end_addr_second <= din_s[ADDR_BITS-1:0];
         else if (sel == REG_CONTROL)
            control_word <= din_s[REG_W-1:0];
      end
   end

   // A hit in the clearing cycle must not be lost, so the set term wins.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         buffer_end_flag_first <= 1'b0;
         buffer_end_flag_second <= 1'b0;
      end
      else
      begin
         buffer_end_flag_first <= seq_end_hit_first
            | (buffer_end_flag_first & ~(ctrl_write & ~din_s[CTRL_FIRST_BIT]));
         buffer_end_flag_second <= seq_end_hit_second
            | (buffer_end_flag_second & ~(ctrl_write & ~din_s[CTRL_SECOND_BIT]));
      end
   end

   always_comb
   begin
      flag_word = '0;
      flag_word[FLAG_FIRST_BIT] = buffer_end_flag_first;
      flag_word[FLAG_SECOND_BIT] = buffer_end_flag_second;
   end

   // Unused register indexes read as zero.
   always_comb
   begin
      reg_read = '0;
      if (sel == REG_START_FIRST)
         reg_read[ADDR_BITS-1:0] = start_addr_first;
      else if (sel == REG_END_FIRST)
         reg_read[ADDR_BITS-1:0] = end_addr_first;
      else if (sel == REG_START_SECOND)
         reg_read[ADDR_BITS-1:0] = start_addr_second;
      else if (sel == REG_END_SECOND)
         reg_read[ADDR_BITS-1:0] = end_addr_second;
      else if (sel == REG_FLAG)
         reg_read[REG_W-1:0] = flag_word;
      else if (sel == REG_CONTROL)
         reg_read[REG_W-1:0] = control_word;
   end

   assign drive = (mode_next != MODE_IDLE) && !oe_s && rw_s;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         random_data_bus_out <= DATA_RESET;
         random_data_bus_oe <= '0;
      end
      else
      begin
         if (mode_next == MODE_CMD)
            random_data_bus_out <= reg_read;
         else
            random_data_bus_out <= mem[a_s];
         random_data_bus_oe <= {{HALF{drive && !high_lane_s}},
                                {HALF{drive && !low_lane_s}}};
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_full_write;
      mode_next == MODE_ARRAY && !rw_s && !low_lane_s && !high_lane_s
         && !(seq_write_en && seq_write_addr == a_s);
   endsequence

   sequence s_same_read;
      mode_next == MODE_ARRAY && rw_s && a_s == $past(a_s);
   endsequence

   sequence s_clear_first;
      ctrl_write && !din_s[CTRL_FIRST_BIT] && !seq_end_hit_first;
   endsequence

   chk_write_then_read: assert property (
      s_full_write ##1 s_same_read |=> random_data_bus_out == $past(din_s, 2))
      else $error("array word read back differs from the word written");

   chk_drive_needs_read: assert property (
      random_data_bus_oe != '0 |-> $past(rw_s) && !$past(oe_s))
      else $error("data bus driven outside a read with output enable low");

   chk_oe_high_floats: assert property (
      oe_s |=> random_data_bus_oe == '0)
      else $error("data bus driven while output enable is high");

   chk_low_lane_gate: assert property (
      $rose(random_data_bus_oe[0]) |-> !$past(low_lane_s) && random_data_bus_oe[HALF-1])
      else $error("low byte driven without its enable");

   chk_high_lane_gate: assert property (
      low_lane_s && !high_lane_s && drive
         |=> random_data_bus_oe == {{HALF{1'b1}}, {HALF{1'b0}}})
      else $error("upper byte lane not independent of lower byte enable");

   chk_deselect_floats: assert property (
      ce_s && cmd_s |=> port_power_down && random_data_bus_oe == '0)
      else $error("deselected port not powered down and floating");

   chk_both_low_idle: assert property (
      !ce_s && !cmd_s ##1 !ce_s && !cmd_s |=> port_power_down && random_data_bus_oe == '0)
      else $error("both selects low were not ignored");

   chk_flag_clear: assert property (
      s_clear_first |=> !buffer_end_flag_first)
      else $error("writing zero to control bit 0 did not clear the first flag");

   chk_set_beats_clear: assert property (
      seq_end_hit_second |=> buffer_end_flag_second)
      else $error("end hit lost");

   chk_reg_write: assert property (
      cmd_write && sel == REG_END_FIRST |=> end_addr_first == $past(din_s[ADDR_BITS-1:0]))
      else $error("end register of first buffer not written");

   chk_select_enables: assert property (
      !ce_s && cmd_s && rw_s && !oe_s && !low_lane_s
         |=> random_data_bus_oe[0] && !port_power_down)
      else $error("selected port failed to drive a read");
endmodule : rap_port

// >>> rap_pkg.sv
// Shared constants and types for the random access port.
package rap_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int REG_W = 13;
   localparam int SEL_W = 3;
   localparam logic [SEL_W-1:0] REG_START_FIRST = 3'h0;
   localparam logic [SEL_W-1:0] REG_END_FIRST = 3'h1;
   localparam logic [SEL_W-1:0] REG_START_SECOND = 3'h2;
   localparam logic [SEL_W-1:0] REG_END_SECOND = 3'h3;
   localparam logic [SEL_W-1:0] REG_FLAG = 3'h4;
   localparam logic [SEL_W-1:0] REG_CONTROL = 3'h5;
   localparam int CTRL_FIRST_BIT = 0;
   localparam int CTRL_SECOND_BIT = 1;
   localparam int FLAG_FIRST_BIT = 0;
   localparam int FLAG_SECOND_BIT = 1;
   localparam logic [REG_W-1:0] CTRL_RESET = 13'h0003;
   localparam logic [ADDR_W-1:0] START_RESET = 12'h000;
   localparam logic [ADDR_W-1:0] END_RESET = 12'hfff;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

   typedef enum logic [2:0]
   {
      MODE_IDLE = 3'b001,
      MODE_ARRAY = 3'b010,
      MODE_CMD = 3'b100
   } rap_mode_t;
endpackage : rap_pkg

// >>> rap_host.sv
// Host processor model driving the random access port pins.
`timescale 1ns/1ps
module rap_host
(
   input wire logic clock,
   output logic [rap_pkg::ADDR_W-1:0] word_address,
   output logic port_select_n,
   output logic reg_select_n,
   output logic read_write_n,
   output logic output_enable_n,
   output logic lower_byte_enable_n,
   output logic upper_byte_enable_n,
   input wire logic [rap_pkg::DATA_W-1:0] random_data_bus_out,
   input wire logic [rap_pkg::DATA_W-1:0] random_data_bus_oe,
   output logic [rap_pkg::DATA_W-1:0] random_data_bus_in
);
   import rap_pkg::*;
   logic [DATA_W-1:0] drive_data = 16'h0000;
   logic [DATA_W-1:0] last_wire = 16'h0000;
   // Undriven bits show the inverse of their last level while read_write_n is high, so stale data never passes; during writes they carry drive_data.
   assign random_data_bus_in = (random_data_bus_oe & random_data_bus_out)
      | (~random_data_bus_oe & (read_write_n ? ~last_wire : drive_data));
   always @(posedge clock) last_wire <= random_data_bus_in;
   task automatic idle(input int n);
      port_select_n = 1'b1;
      reg_select_n = 1'b1;
      read_write_n = 1'b1;
      output_enable_n = 1'b1;
      {upper_byte_enable_n, lower_byte_enable_n} = 2'b11;
      repeat (n) @(negedge clock);
   endtask : idle
   initial idle(0);
   task automatic apply(input logic arr_n, input logic cmd_n, input logic rw_n,
      input logic oe_n, input logic [1:0] ln, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] dv, output logic [DATA_W-1:0] seen,
      output logic [DATA_W-1:0] seen_oe);
      @(negedge clock);
      port_select_n = arr_n | ~cmd_n;
      reg_select_n = cmd_n;
      read_write_n = rw_n;
      output_enable_n = oe_n;
      {upper_byte_enable_n, lower_byte_enable_n} = ln;
      word_address = ad;
      drive_data = dv;
      repeat (5) @(negedge clock);
      seen = random_data_bus_in;
      seen_oe = random_data_bus_oe;
   endtask : apply
endmodule : rap_host

// >>> rap_port_bench.sv
// Self-checking bench for the random access port against a behavioural model.
`timescale 1ns/1ps
module rap_port_bench;
   import rap_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] word_address, seq_write_addr, seq_read_addr, a;
   logic port_select_n, reg_select_n, read_write_n, output_enable_n;
   logic lower_byte_enable_n, upper_byte_enable_n, port_power_down;
   logic [DATA_W-1:0] random_data_bus_in, random_data_bus_out, random_data_bus_oe;
   logic [DATA_W-1:0] seq_write_data, seq_read_data, seen, seen_oe, m;
   logic seq_write_en = 1'b0, seq_end_hit_first = 1'b0, seq_end_hit_second = 1'b0;
   logic [ADDR_W-1:0] start_addr_first, end_addr_first, start_addr_second, end_addr_second;
   logic [REG_W-1:0] control_word;
   logic buffer_end_flag_first, buffer_end_flag_second;
   int fails = 0;
   int tests_run = 0;
   int seed = 32'h3949;
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] regs [8] = '{16'(START_RESET), 16'(END_RESET), 16'(START_RESET),
      16'(END_RESET), 16'h0, 16'(CTRL_RESET), 16'h0, 16'h0};
   always #2 clock = ~clock;
   rap_port rap_port_i (.clock, .rst, .word_address, .port_select_n, .reg_select_n,
      .read_write_n, .output_enable_n, .lower_byte_enable_n, .upper_byte_enable_n,
      .random_data_bus_in, .random_data_bus_out, .random_data_bus_oe, .port_power_down,
      .seq_write_en, .seq_write_addr, .seq_write_data, .seq_read_addr, .seq_read_data,
      .seq_end_hit_first, .seq_end_hit_second, .start_addr_first, .end_addr_first,
      .start_addr_second, .end_addr_second, .control_word, .buffer_end_flag_first,
      .buffer_end_flag_second);
   rap_host rap_host_i (.clock, .word_address, .port_select_n, .reg_select_n,
      .read_write_n, .output_enable_n, .lower_byte_enable_n, .upper_byte_enable_n,
      .random_data_bus_out, .random_data_bus_oe, .random_data_bus_in);
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic test_done();
      $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic arr_wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dv,
      input logic [1:0] ln);
      m = {{8{~ln[1]}}, {8{~ln[0]}}};
      mem[ad] = (mem[ad] & ~m) | (dv & m);
      rap_host_i.apply(1'b0, 1'b1, 1'b0, 1'b0, ln, ad, dv, seen, seen_oe);
      check("write drive", seen_oe, 0);
      check("active power", port_power_down, 0);
      rap_host_i.idle(4);
      check("idle drive", random_data_bus_oe, 0);
      check("idle power", port_power_down, 1);
   endtask : arr_wr
   task automatic arr_rd(input logic [ADDR_W-1:0] ad, input logic [1:0] ln, input logic oe_n);
      rap_host_i.apply(1'b0, 1'b1, 1'b1, oe_n, ln, ad, 16'h0, seen, seen_oe);
      m = oe_n ? 16'h0 : {{8{~ln[1]}}, {8{~ln[0]}}};
      check("read drive", seen_oe, m);
      check("read data", seen & m, mem[ad] & m);
      rap_host_i.idle(4);
   endtask : arr_rd
   task automatic reg_acc(input logic [2:0] ix, input logic rw_n, input logic [DATA_W-1:0] v);
      rap_host_i.apply(1'b1, 1'b0, rw_n, 1'b0, 2'b00, {a[11:3], ix}, v, seen, seen_oe);
      if (rw_n)
      begin
         check("reg drive", seen_oe, 16'hffff);
         check("reg data", seen, regs[ix]);
      end
      else if (ix < 4)
         regs[ix] = {4'h0, v[11:0]};
      else if (ix == 5)
      begin
         regs[5] = {3'h0, v[12:0]};
         regs[4] = regs[4] & {14'h3fff, v[1:0]};
      end
      rap_host_i.idle(4);
   endtask : reg_acc
   initial
   begin
      seq_write_addr = 12'h0;
      seq_read_addr = 12'h0;
      seq_write_data = 16'h0;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      check("control reset", control_word, CTRL_RESET);
      check("end reset", end_addr_second, END_RESET);
      check("reset power", port_power_down, 1);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         a = 12'($random(seed));
         arr_wr(a, 16'($random(seed)), 2'b00);
         arr_wr(a, ~mem[a], i[1:0]);
         arr_rd(a, 2'b00, 1'b0);
         arr_rd(a, ~i[1:0], 1'b0);
         arr_rd(a, 2'b00, 1'b1);
      end
      $display("test array done");
      seq_write_addr = a;
      seq_write_data = 16'($random(seed));
      seq_write_en = 1'b1;
      @(negedge clock);
      seq_write_en = 1'b0;
      mem[a] = seq_write_data;
      seq_read_addr = a;
      repeat (2) @(negedge clock);
      check("seq read", seq_read_data, mem[a]);
      arr_rd(a, 2'b00, 1'b0);
      // A write turned straight into a read of the same word must return the new data.
      m = 16'($random(seed));
      mem[a] = m;
      rap_host_i.apply(1'b0, 1'b1, 1'b0, 1'b0, 2'b00, a, m, seen, seen_oe);
      rap_host_i.apply(1'b0, 1'b1, 1'b1, 1'b0, 2'b00, a, 16'h0, seen, seen_oe);
      check("turnaround drive", seen_oe, 16'hffff);
      check("turnaround data", seen, mem[a]);
      rap_host_i.idle(4);
      $display("test sequential done");
      for (int i = 0; i < 8; i++)
      begin
         reg_acc(i[2:0], 1'b0, 16'($random(seed)));
         reg_acc(i[2:0], 1'b1, 16'h0);
      end
      check("start port", start_addr_second, regs[2]);
      check("end port", end_addr_first, regs[1]);
      check("start first port", start_addr_first, regs[0]);
      check("end second port", end_addr_second, regs[3]);
      check("control port", control_word, regs[5]);
      $display("test registers done");
      seq_end_hit_first = 1'b1;
      seq_end_hit_second = 1'b1;
      @(negedge clock);
      seq_end_hit_first = 1'b0;
      seq_end_hit_second = 1'b0;
      regs[4] = 16'h3;
      for (int i = 0; i < 3; i++)
      begin
         if (i > 0)
            reg_acc(3'h5, 1'b0, 16'h1fff ^ 16'(i));
         check("flags", {buffer_end_flag_second, buffer_end_flag_first}, regs[4]);
         reg_acc(3'h4, 1'b1, 16'h0);
      end
      $display("test flags done");
      test_done();
   end
   // A full run needs under two thousand nanoseconds; this bound leaves ample margin.
   initial
   begin
      #100000;
      fails++;
      test_done();
   end
endmodule : rap_port_bench
